// file: common/iomp_regs.vh
// register map, field positions and timing constants of the i/o monitor and position capture block
// assumes word addresses of the 16-bit register port; 32-bit values take two words
`ifndef IOMP_REGS_VH
`define IOMP_REGS_VH

`define IOMP_ADDR_W            16
`define IOMP_DATA_W            16
`define IOMP_POS_W             32

// word addresses, low half in little-endian order
`define IOMP_ADDR_INPUT_LEVELS  16'h03f0
`define IOMP_ADDR_OUTPUT_LEVELS 16'h03f2
`define IOMP_ADDR_FALL_POS      16'h03f6
`define IOMP_ADDR_RISE_POS      16'h03f8
`define IOMP_ADDR_CAP_STATUS    16'h03fa
`define IOMP_ADDR_CAP_CONTROL   16'h042a
`define IOMP_ADDR_HALF_STEP     16'h0001

// input_levels fields
`define IOMP_IN_NEG_LIMIT      0
`define IOMP_IN_POS_LIMIT      1
`define IOMP_IN_PROXIMITY      2
`define IOMP_IN_GEN_LSB        16
`define IOMP_IN_TORQUE_OFF     24

// output_levels fields
`define IOMP_OUT_BRAKE         0
`define IOMP_OUT_GEN_LSB       16

// capture_status fields
`define IOMP_ST_ENABLED        0
`define IOMP_ST_RISE_DONE      1
`define IOMP_ST_FALL_DONE      2
`define IOMP_ST_SOURCE         6
`define IOMP_ST_LEVEL          7

// capture_control fields
`define IOMP_CTL_ENABLE        0
`define IOMP_CTL_SOURCE        2
`define IOMP_CTL_RISE_EN       4
`define IOMP_CTL_FALL_EN       5
`define IOMP_CTL_RESET         16'h0000
`define IOMP_CTL_MASK          16'h0035

`define IOMP_POS_RESET         32'h0000_0000
`define IOMP_WORD_ZERO         16'h0000

// capture latency bound and clock rate
`define IOMP_CLK_HZ            50000000
`define IOMP_CAP_DELAY_MAX_US  300
`define IOMP_CAP_DELAY_MAX_CYC ((`IOMP_CAP_DELAY_MAX_US * (`IOMP_CLK_HZ / 1000000)))

`endif

// file: design/iomp_sync.v
// three-stage synchroniser with agreement filter for one pin input
// assumes the input is asynchronous to i_clk; output moves once stages two and three agree
module iomp_sync #(
	parameter RST_VAL = 1'b0
) (
	input  wire i_clk,  // system clock
	input  wire i_rst,  // async reset, active high
	input  wire i_pin,  // raw pin level
	output wire o_lvl   // filtered synchronised level
);
	reg s1_ff;
	reg s2_ff;
	reg s3_ff;
	reg lvl_ff;

	// stage one is read only by stage two
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s1_ff  <= RST_VAL;
			s2_ff  <= RST_VAL;
			s3_ff  <= RST_VAL;
			lvl_ff <= RST_VAL;
		end else begin
			s1_ff <= i_pin;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff) begin
				lvl_ff <= s3_ff;
			end
		end
	end

	assign o_lvl = lvl_ff;
endmodule

// file: design/iomp_top.v
// i/o status monitor, travel-limit handling and encoder position capture
// assumes one system clock; encoder count, torque-off state and outputs come from logic on i_clk
//
// Overview of operation
// R1: input word: neg limit b0, pos limit b1, proximity b2, general inputs b16-19.
// R2: both limit inputs on in limit mode means no motion restriction.
// R3: any limit input going off sets internal-limit-active, status word bit 11.
// R4: limit input going off starts a halt-style deceleration to standstill.
// R5: after a limit stop only opposite motion allowed until that limit is on.
// R6: torque-off variant shows torque-off state at input bit 24 when setup bit 7 set.
// R7: output word: brake-release b0, general outputs b16-19, rest reserved.
// R8: falling edge of capture signal stores position in falling-edge pair.
// R9: rising edge of capture signal stores position in rising-edge pair.
// R10: capture status bit 0 shows capture enabled.
// R11: status bit 1 set after rising capture, bit 2 after falling capture.
// R12: status bit 6 shows source: zero probe input, one encoder index.
// R13: status bit 7 shows present level of the selected capture signal.
// R14: control bit 0 enables capture; re-enabling clears stored positions.
// R15: control bit 2 selects source: general input three or encoder index.
// R16: control bit 4 enables rising-edge capture.
// R17: control bit 5 enables falling-edge capture.
// R18: position is captured within 300 us of the input switching.
// R19: software enables only one capture edge, chosen when enabling.
// R20: positions are signed 32-bit, read as two words in selectable order.
// R21: capture source synchronised, edges found on synchronised level latch position.
// R22: clearing capture enable also clears both captured flags.
`include "iomp_regs.vh"

module iomp_top (
	input  wire        i_clk,                        // system clock, 50 mhz
	input  wire        i_rst,                        // async reset, active high
	input  wire        i_neg_limit,                  // negative limit pin, high = on
	input  wire        i_pos_limit,                  // positive limit pin, high = on
	input  wire        i_proximity_input,            // proximity pin
	input  wire        i_general_input_zero,         // general input pin
	input  wire        i_general_input_one,          // general input pin
	input  wire        i_general_input_two,          // general input pin
	input  wire        i_general_input_three,        // general input pin, probe source
	input  wire        i_enc_index,                  // encoder index pulse pin
	input  wire [31:0] i_enc_position,               // live encoder count, signed
	input  wire        i_limit_mode,                 // inputs one and two act as limits
	input  wire        i_torque_off_variant,         // device has torque-off channels
	input  wire        i_torque_off_report_en,       // input setup bit 7
	input  wire        i_safe_torque_cutoff_state,   // drive in torque-off state
	input  wire        i_brake_release_out,          // brake-release output level
	input  wire        i_general_output_zero,        // general output level
	input  wire        i_general_output_one,         // general output level
	input  wire        i_general_output_two,         // general output level
	input  wire        i_general_output_three,       // general output level
	input  wire        i_motor_stopped,              // motor at standstill
	input  wire        i_big_endian,                 // word order of 32-bit reads
	input  wire [15:0] i_reg_addr,                   // register word address
	input  wire        i_reg_rd,                     // read strobe, one cycle
	input  wire        i_reg_wr,                     // write strobe, one cycle
	input  wire [15:0] i_reg_wdata,                  // write data
	output wire [15:0] o_reg_rdata,                  // read data, registered
	output wire        o_reg_ack,                    // access done, one-cycle pulse
	output wire        o_reg_err,                    // unmapped address, with ack
	output wire        o_internal_limit_active,      // status word bit 11
	output wire        o_halt_request,               // decelerate to standstill
	output wire        o_block_pos_motion,           // positive motion inhibited
	output wire        o_block_neg_motion            // negative motion inhibited
);
	localparam NPIN = 8;

	wire [NPIN-1:0] pin_raw;
	wire [NPIN-1:0] pin_lvl;

	assign pin_raw = {i_enc_index, i_general_input_three, i_general_input_two, i_general_input_one,
		i_general_input_zero, i_proximity_input, i_pos_limit, i_neg_limit};

	// sync resets low while limit pins idle high: in limit mode the blocks show until the pins pass
	genvar g;
	generate
		for (g = 0; g < NPIN; g = g + 1) begin : g_sync
			iomp_sync #(
				.RST_VAL (1'b0)
			) u_sync (
				.i_clk (i_clk),
				.i_rst (i_rst),
				.i_pin (pin_raw[g]),
				.o_lvl (pin_lvl[g])
			);
		end
	endgenerate

	wire       neg_lvl;
	wire       pos_lvl;
	wire       prox_lvl;
	wire [3:0] gen_lvl;
	wire       idx_lvl;

	assign neg_lvl  = pin_lvl[0];
	assign pos_lvl  = pin_lvl[1];
	assign prox_lvl = pin_lvl[2];
	assign gen_lvl  = pin_lvl[6:3];
	assign idx_lvl  = pin_lvl[7];

	// status words
	reg [31:0] in_word;
	reg [31:0] out_word;

	always @* begin
		in_word = 32'h0000_0000;
		in_word[`IOMP_IN_NEG_LIMIT] = neg_lvl; // see R1
		in_word[`IOMP_IN_POS_LIMIT] = pos_lvl;
		in_word[`IOMP_IN_PROXIMITY] = prox_lvl;
		in_word[`IOMP_IN_GEN_LSB +: 4] = gen_lvl;
		in_word[`IOMP_IN_TORQUE_OFF] = i_torque_off_variant & i_torque_off_report_en
			& i_safe_torque_cutoff_state; // see R6
	end

	always @* begin
		out_word = 32'h0000_0000;
		out_word[`IOMP_OUT_BRAKE] = i_brake_release_out; // see R7
		out_word[`IOMP_OUT_GEN_LSB +: 4] = {i_general_output_three, i_general_output_two,
			i_general_output_one, i_general_output_zero};
	end

	// travel limits
	reg neg_prev_ff;
	reg pos_prev_ff;
	reg halt_ff;
	reg nxt_halt;

	// a tripped limit stays a block while its input is off, so the inhibit tracks the pin
	wire neg_trip;
	wire pos_trip;
	wire neg_fall;
	wire pos_fall;

	assign neg_trip = i_limit_mode & ~neg_lvl; // see R2
	assign pos_trip = i_limit_mode & ~pos_lvl; // see R2
	assign neg_fall = i_limit_mode & neg_prev_ff & ~neg_lvl;
	assign pos_fall = i_limit_mode & pos_prev_ff & ~pos_lvl;

	always @* begin
		nxt_halt = halt_ff;
		if (i_motor_stopped) begin
			nxt_halt = 1'b0;
		end
		// a new trip wins over the standstill clear
		if (neg_fall | pos_fall) begin
			nxt_halt = 1'b1; // see R4
		end
	end

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			neg_prev_ff <= 1'b0;
			pos_prev_ff <= 1'b0;
			halt_ff     <= 1'b0;
		end else begin
			neg_prev_ff <= neg_lvl;
			pos_prev_ff <= pos_lvl;
			halt_ff     <= nxt_halt;
		end
	end

	assign o_internal_limit_active = neg_trip | pos_trip; // see R3
	assign o_halt_request          = halt_ff;
	assign o_block_neg_motion      = neg_trip; // see R5
	assign o_block_pos_motion      = pos_trip; // see R5

	// capture control
	reg [15:0] ctl_ff;
	reg [15:0] nxt_ctl;
	wire       ctl_wr;

	// only the four defined control bits are kept, the rest read back as zero
	assign ctl_wr = i_reg_wr & (i_reg_addr == `IOMP_ADDR_CAP_CONTROL);

	always @* begin
		nxt_ctl = ctl_ff;
		if (ctl_wr) begin
			nxt_ctl = i_reg_wdata & `IOMP_CTL_MASK;
		end
	end

	wire cap_en;
	wire cap_src;
	wire rise_en;
	wire fall_en;
	wire enabling;

	assign cap_en   = ctl_ff[`IOMP_CTL_ENABLE];
	assign cap_src  = ctl_ff[`IOMP_CTL_SOURCE];
	assign rise_en  = ctl_ff[`IOMP_CTL_RISE_EN];
	assign fall_en  = ctl_ff[`IOMP_CTL_FALL_EN];
	assign enabling = ~cap_en & nxt_ctl[`IOMP_CTL_ENABLE];

	// capture engine
	// i_enc_position is on i_clk already, so it is taken without a synchroniser
	reg        src_prev_ff;
	reg        lvl_prev_ff;
	reg        rise_done_ff;
	reg        fall_done_ff;
	reg [31:0] rise_pos_ff;
	reg [31:0] fall_pos_ff;
	reg        nxt_rise_done;
	reg        nxt_fall_done;
	reg [31:0] nxt_rise_pos;
	reg [31:0] nxt_fall_pos;

	wire sel_lvl;
	wire src_steady;
	wire edge_rise;
	wire edge_fall;

	assign sel_lvl    = cap_src ? idx_lvl : gen_lvl[3]; // see R15
	// a source switch can fake an edge, so the cycle after a change is ignored
	assign src_steady = (src_prev_ff == cap_src);
	// sync plus edge stage is a handful of cycles, far inside the latency bound; see R18
	assign edge_rise  = src_steady & sel_lvl & ~lvl_prev_ff; // see R21
	assign edge_fall  = src_steady & ~sel_lvl & lvl_prev_ff; // see R21

	always @* begin
		nxt_rise_done = rise_done_ff;
		nxt_fall_done = fall_done_ff;
		nxt_rise_pos  = rise_pos_ff;
		nxt_fall_pos  = fall_pos_ff;
		if (!cap_en) begin
			nxt_rise_done = 1'b0; // see R22
			nxt_fall_done = 1'b0;
		end else begin
			if (edge_rise & rise_en) begin
				nxt_rise_pos  = i_enc_position; // see R9, R16
				nxt_rise_done = 1'b1; // see R11
			end
			if (edge_fall & fall_en) begin
				nxt_fall_pos  = i_enc_position; // see R8, R17
				nxt_fall_done = 1'b1; // see R11
			end
		end
		// both edges enabled together is left to software; each still works on its own, see R19
		if (enabling) begin
			nxt_rise_pos = `IOMP_POS_RESET; // see R14
			nxt_fall_pos = `IOMP_POS_RESET;
		end
	end

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctl_ff       <= `IOMP_CTL_RESET;
			src_prev_ff  <= 1'b0;
			lvl_prev_ff  <= 1'b0;
			rise_done_ff <= 1'b0;
			fall_done_ff <= 1'b0;
			rise_pos_ff  <= `IOMP_POS_RESET;
			fall_pos_ff  <= `IOMP_POS_RESET;
		end else begin
			ctl_ff       <= nxt_ctl;
			src_prev_ff  <= cap_src;
			lvl_prev_ff  <= sel_lvl;
			rise_done_ff <= nxt_rise_done;
			fall_done_ff <= nxt_fall_done;
			rise_pos_ff  <= nxt_rise_pos;
			fall_pos_ff  <= nxt_fall_pos;
		end
	end

	reg [15:0] cap_status;

	always @* begin
		cap_status = `IOMP_WORD_ZERO;
		cap_status[`IOMP_ST_ENABLED]   = cap_en; // see R10
		cap_status[`IOMP_ST_RISE_DONE] = rise_done_ff; // see R11
		cap_status[`IOMP_ST_FALL_DONE] = fall_done_ff;
		cap_status[`IOMP_ST_SOURCE]    = cap_src; // see R12
		// filtered level, a few cycles behind the pin
		cap_status[`IOMP_ST_LEVEL]     = sel_lvl; // see R13
	end

	// register read port
	// halves are read one at a time, so a capture between the two reads can tear a value
	function [15:0] half_sel;
		input [31:0] word;
		input        upper_addr;
		input        big;
		begin
			// little endian: base word low half; big endian: base word high half
			half_sel = (upper_addr ^ big) ? word[31:16] : word[15:0];
		end
	endfunction

	reg [15:0] rdata_ff;
	reg        ack_ff;
	reg        err_ff;
	reg [15:0] nxt_rdata;
	reg        hit;

	always @* begin
		nxt_rdata = `IOMP_WORD_ZERO;
		hit       = 1'b1;
		case (i_reg_addr)
			`IOMP_ADDR_INPUT_LEVELS:
				nxt_rdata = half_sel(in_word, 1'b0, i_big_endian);
			`IOMP_ADDR_INPUT_LEVELS + `IOMP_ADDR_HALF_STEP:
				nxt_rdata = half_sel(in_word, 1'b1, i_big_endian);
			`IOMP_ADDR_OUTPUT_LEVELS:
				nxt_rdata = half_sel(out_word, 1'b0, i_big_endian);
			`IOMP_ADDR_OUTPUT_LEVELS + `IOMP_ADDR_HALF_STEP:
				nxt_rdata = half_sel(out_word, 1'b1, i_big_endian);
			`IOMP_ADDR_FALL_POS:
				nxt_rdata = half_sel(fall_pos_ff, 1'b0, i_big_endian); // see R20
			`IOMP_ADDR_FALL_POS + `IOMP_ADDR_HALF_STEP:
				nxt_rdata = half_sel(fall_pos_ff, 1'b1, i_big_endian);
			`IOMP_ADDR_RISE_POS:
				nxt_rdata = half_sel(rise_pos_ff, 1'b0, i_big_endian); // see R20
			`IOMP_ADDR_RISE_POS + `IOMP_ADDR_HALF_STEP:
				nxt_rdata = half_sel(rise_pos_ff, 1'b1, i_big_endian);
			`IOMP_ADDR_CAP_STATUS:
				nxt_rdata = cap_status;
			`IOMP_ADDR_CAP_CONTROL:
				nxt_rdata = ctl_ff;
			default: begin
				nxt_rdata = `IOMP_WORD_ZERO;
				hit       = 1'b0;
			end
		endcase
	end

	// writes to read-only words are acknowledged and dropped
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_ff <= `IOMP_WORD_ZERO;
			ack_ff   <= 1'b0;
			err_ff   <= 1'b0;
		end else begin
			ack_ff <= i_reg_rd | i_reg_wr;
			err_ff <= (i_reg_rd | i_reg_wr) & ~hit;
			if (i_reg_rd) begin
				rdata_ff <= nxt_rdata;
			end
		end
	end

	assign o_reg_rdata = rdata_ff;
	assign o_reg_ack   = ack_ff;
	assign o_reg_err   = err_ff;
endmodule

// file: tb/iomp_properties.sv
// concurrent checks on the register port and limit outputs of the i/o monitor block
// assumes binding to iomp_top; single clock domain, async active-high reset
module iomp_properties (
	input wire        i_clk,                   // system clock
	input wire        i_rst,                   // async reset
	input wire        i_reg_rd,                // read strobe
	input wire        i_reg_wr,                // write strobe
	input wire        i_limit_mode,            // limit mode
	input wire        i_motor_stopped,         // standstill
	input wire [15:0] o_reg_rdata,             // read data
	input wire        o_reg_ack,               // access done
	input wire        o_reg_err,               // unmapped
	input wire        o_internal_limit_active, // limit flag
	input wire        o_halt_request,          // halt
	input wire        o_block_pos_motion,      // positive inhibit
	input wire        o_block_neg_motion       // negative inhibit
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);

	ack_after_access_a:
		assert property ((i_reg_rd || i_reg_wr) |=> o_reg_ack) else $error("no ack after access");
	ack_needs_access_a:
		assert property (o_reg_ack |-> $past(i_reg_rd || i_reg_wr)) else $error("ack without access");
	err_with_ack_a:
		assert property (o_reg_err |-> o_reg_ack) else $error("err without ack");
	rdata_hold_a:
		assert property (!i_reg_rd |=> $stable(o_reg_rdata)) else $error("rdata moved without read");
	limit_flag_a:
		assert property (o_internal_limit_active == (o_block_pos_motion || o_block_neg_motion))
			else $error("limit flag disagrees with inhibits");
	block_mode_a:
		assert property ((o_block_pos_motion || o_block_neg_motion) |-> i_limit_mode)
			else $error("inhibit outside limit mode");
	halt_start_a:
		assert property (($rose(o_block_neg_motion) || $rose(o_block_pos_motion)) && $past(i_limit_mode)
			&& i_limit_mode |=> o_halt_request) else $error("no halt after limit off");
	halt_hold_a:
		assert property (o_halt_request && !i_motor_stopped |=> o_halt_request) else $error("halt dropped early");
	halt_clear_a:
		assert property (o_halt_request && i_motor_stopped && $stable(o_block_neg_motion)
			&& $stable(o_block_pos_motion) |=> !o_halt_request) else $error("halt kept at standstill");

	cover property (o_reg_err);
	cover property ($rose(o_halt_request));
	cover property (o_halt_request && i_motor_stopped);
endmodule

// file: tb/iomp_partner.sv
// motor and encoder stand-in beyond the limit logic
// assumes the bench commands motion; shares the block's clock
module iomp_partner (
	input  wire logic        i_clk,           // system clock
	input  wire logic        i_rst,           // async reset
	input  wire logic        i_move,          // motion commanded
	input  wire logic        i_dir_pos,       // high = positive
	input  wire logic        i_halt,          // halt from the block
	output wire logic [31:0] o_enc_position,  // encoder count
	output wire logic        o_motor_stopped  // standstill
);
	logic [3:0]  slow_ff;
	logic [31:0] pos_ff;
	// halt ramps down over four cycles, so halt must hold until standstill
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			slow_ff <= 4'h0;
			pos_ff <= 32'h0000_0000;
		end else begin
			slow_ff <= i_halt ? {slow_ff[2:0], 1'b1} : 4'h0;
			if (!o_motor_stopped)
				pos_ff <= i_dir_pos ? pos_ff + 32'h1 : pos_ff - 32'h1;
		end
	end
	assign o_motor_stopped = !i_move || slow_ff[3];
	assign o_enc_position = pos_ff;
endmodule

// file: tb/iomp_top_bench.sv
// self-checking bench for the i/o monitor and position capture block
// assumes inputs change at falling edges; partner model provides encoder and standstill
module iomp_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, rst = 1, neg = 1, pos = 1, prox = 0, index = 0, lmode = 0;
	logic        tov = 0, toen = 0, tocut = 0, brake = 0, big = 0, rds = 0, wr = 0, move = 0, dirp = 0;
	logic [3:0]  gin = 4'h0, gout = 4'h0;
	logic [15:0] addr = 16'h0000, wdata = 16'h0000;
	logic [31:0] v;
	wire  [15:0] rdata;
	wire  [31:0] enc;
	wire         ack, err, lim, halt, bpos, bneg, stopped;
	int          num_errors = 0, n_tests = 0, cyc = 0;

	always #10 clk = ~clk;

	iomp_top iomp_top_inst (.i_clk(clk), .i_rst(rst), .i_neg_limit(neg), .i_pos_limit(pos),
		.i_proximity_input(prox), .i_general_input_zero(gin[0]), .i_general_input_one(gin[1]),
		.i_general_input_two(gin[2]), .i_general_input_three(gin[3]), .i_enc_index(index),
		.i_enc_position(enc), .i_limit_mode(lmode), .i_torque_off_variant(tov),
		.i_torque_off_report_en(toen), .i_safe_torque_cutoff_state(tocut), .i_brake_release_out(brake),
		.i_general_output_zero(gout[0]), .i_general_output_one(gout[1]), .i_general_output_two(gout[2]),
		.i_general_output_three(gout[3]), .i_motor_stopped(stopped), .i_big_endian(big),
		.i_reg_addr(addr), .i_reg_rd(rds), .i_reg_wr(wr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
		.o_reg_ack(ack), .o_reg_err(err), .o_internal_limit_active(lim), .o_halt_request(halt),
		.o_block_pos_motion(bpos), .o_block_neg_motion(bneg));

	iomp_partner iomp_partner_inst (.i_clk(clk), .i_rst(rst), .i_move(move), .i_dir_pos(dirp),
		.i_halt(halt), .o_enc_position(enc), .o_motor_stopped(stopped));

	task final_report;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// strobe taken at the next rising edge; ack stands only until the edge after, so look at once
	task rd(input logic [15:0] a, input logic [15:0] exp, input logic e);
		@(negedge clk) addr = a;
		rds = 1'b1;
		@(negedge clk) rds = 1'b0;
		check({ack, err, rdata}, {1'b1, e, exp});
	endtask

	task wrt(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk) addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk) wr = 1'b0;
		check({ack, err}, 2'b10);
	endtask

	// pins pass a three-stage filter, so give them time to land
	task settle;
		repeat (8) @(negedge clk);
	endtask

	task t_regs;
		rd(16'h03fa, 16'h0000, 1'b0);
		rd(16'h0100, 16'h0000, 1'b1);
		wrt(16'h03fa, 16'hffff);
		rd(16'h03fa, 16'h0000, 1'b0);
		wrt(16'h042a, 16'hffca);
		rd(16'h042a, 16'h0000, 1'b0);
	endtask

	task t_levels;
		neg = 1;
		pos = 0;
		prox = 1;
		gin = 4'ha;
		tov = 1;
		toen = 1;
		tocut = 1;
		brake = 1;
		gout = 4'h5;
		settle;
		rd(16'h03f0, 16'h0005, 1'b0);
		rd(16'h03f1, 16'h010a, 1'b0);
		big = 1;
		rd(16'h03f0, 16'h010a, 1'b0);
		big = 0;
		toen = 0;
		rd(16'h03f1, 16'h000a, 1'b0);
		rd(16'h03f2, 16'h0001, 1'b0);
		rd(16'h03f3, 16'h0005, 1'b0);
		pos = 1;
		prox = 0;
		gin = 4'h0;
		settle;
	endtask

	task t_rise;
		move = 1;
		repeat (5) @(negedge clk);
		move = 0;
		wrt(16'h042a, 16'h0011);
		rd(16'h03fa, 16'h0001, 1'b0);
		v = enc;
		gin[3] = 1;
		settle;
		rd(16'h03fa, 16'h0083, 1'b0);
		rd(16'h03f8, v[15:0], 1'b0);
		rd(16'h03f9, v[31:16], 1'b0);
		gin[3] = 0;
		settle;
		rd(16'h03fa, 16'h0003, 1'b0);
	endtask

	task t_fall;
		wrt(16'h042a, 16'h0000);
		rd(16'h03fa, 16'h0000, 1'b0);
		wrt(16'h042a, 16'h0025);
		rd(16'h03f8, 16'h0000, 1'b0);
		rd(16'h03f9, 16'h0000, 1'b0);
		rd(16'h03fa, 16'h0041, 1'b0);
		index = 1;
		settle;
		rd(16'h03fa, 16'h00c1, 1'b0);
		move = 1;
		dirp = 1;
		repeat (3) @(negedge clk);
		move = 0;
		v = enc;
		index = 0;
		settle;
		rd(16'h03fa, 16'h0045, 1'b0);
		big = 1;
		rd(16'h03f6, v[31:16], 1'b0);
		rd(16'h03f7, v[15:0], 1'b0);
		big = 0;
	endtask

	task t_limit;
		lmode = 1;
		settle;
		check({lim, bpos, bneg}, 3'b000);
		dirp = 0;
		move = 1;
		neg = 0;
		for (int i = 0; i < 10 && halt !== 1'b1; i++) @(negedge clk);
		check(halt, 1'b1);
		check({lim, bpos, bneg}, 3'b101);
		for (int i = 0; i < 12 && halt !== 1'b0; i++) @(negedge clk);
		check({halt, stopped}, 2'b01);
		move = 0;
		rd(16'h03f0, 16'h0002, 1'b0);
		neg = 1;
		settle;
		check({lim, bpos, bneg}, 3'b000);
		pos = 0;
		settle;
		check({lim, bpos, bneg}, 3'b110);
		pos = 1;
		settle;
	endtask

	// ceiling well above the roughly 160 cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			final_report;
		end
	end

	initial begin
		repeat (3) @(negedge clk);
		rst = 0;
		t_regs;
		t_levels;
		t_rise;
		t_fall;
		t_limit;
		final_report;
	end
endmodule

bind iomp_top iomp_properties iomp_properties_inst (.i_clk(i_clk), .i_rst(i_rst), .i_reg_rd(i_reg_rd),
	.i_reg_wr(i_reg_wr), .i_limit_mode(i_limit_mode), .i_motor_stopped(i_motor_stopped),
	.o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack), .o_reg_err(o_reg_err),
	.o_internal_limit_active(o_internal_limit_active), .o_halt_request(o_halt_request),
	.o_block_pos_motion(o_block_pos_motion), .o_block_neg_motion(o_block_neg_motion));
